// File: pmac_params.svh
// Constants of the power monitor alert control block
`ifndef PMAC_PARAMS_SVH
`define PMAC_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PMAC_CLK_KHZ       25000
`define PMAC_US_CYC        (`PMAC_CLK_KHZ / 1000)
`define PMAC_SETTLE_US     300
`define PMAC_CT_MIN_US     13'd50
`define PMAC_CT_MAX_US     13'd4120
`define PMAC_CT_RST_US     13'd1052
`define PMAC_AVG_MAX_LOG2  4'ha

// ----------------------------------------------------------------------
// Register pointers
// ----------------------------------------------------------------------
`define PMAC_A_CFG         8'h00
`define PMAC_A_ADC_CFG     8'h01
`define PMAC_A_CT_SHUNT    8'h02
`define PMAC_A_CT_RAIL     8'h03
`define PMAC_A_CT_HEAT     8'h04
`define PMAC_A_AVG         8'h05
`define PMAC_A_THR_FIRST   8'h06
`define PMAC_A_THR_LAST    8'h0b
`define PMAC_A_DIAG        8'h0c
`define PMAC_A_RES_FIRST   8'h0d
`define PMAC_A_RES_LAST    8'h10

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define PMAC_CFG_RST_BIT   15
`define PMAC_MODE_SHUT     2'h0
`define PMAC_MODE_TRIG     2'h1
`define PMAC_MODE_CONT     2'h2
`define PMAC_DG_HOLD       15
`define PMAC_DG_CONVERSION_DONE_ALERT_ENABLE       14
`define PMAC_DG_SLOW       13
`define PMAC_DG_INV        12
`define PMAC_DG_OVF        9
`define PMAC_DG_MEM        8
`define PMAC_DG_DONE       7
`define PMAC_NO_CH         2'h3

// ----------------------------------------------------------------------
// Threshold reset values
// ----------------------------------------------------------------------
`define PMAC_RST_SHUNT_LOW  16'h8000
`define PMAC_RST_SHUNT_HIGH 16'h7fff
`define PMAC_RST_RAIL_HIGH  16'h7fff
`define PMAC_RST_RAIL_LOW   16'h0000
`define PMAC_RST_DIE_HEAT   16'hffff
`define PMAC_RST_POWER      16'h7fff

`endif

// File: pmac_pkg.sv
// Types of the power monitor alert control block
package pmac_pkg;

  typedef enum logic [1:0] {
    PMAC_SETTLE,
    PMAC_IDLE,
    PMAC_CONV,
    PMAC_WAIT
  } pmac_state_t;

  typedef struct packed {
    pmac_state_t        state;
    logic [4:0]         us_div;
    logic [12:0]        us_cnt;
    logic [15:0]        settle_cnt;
    logic [10:0]        avg_cnt;
    logic [1:0]         ch;
    logic               go;
    logic [1:0]         mode;
    logic [2:0]         chen;
    logic [2:0][12:0]   ct;
    logic [3:0]         avg_log2;
    logic [2:0][26:0]   acc;
    logic [3:0][15:0]   res;
    logic               hold_en;
    logic               conversion_done_alert_enable_en;
    logic               slow_en;
    logic               invert;
    logic [5:0]         flags;
    logic               done_flag;
    logic               ovf_flag;
    logic               alert_hold;
    logic               alert_oe;
    logic               alert_o;
    logic [15:0]        rdata;
    logic               adc_start;
    logic               filter_clear;
    logic [1:0]         ch_out;
    logic [12:0]        ct_out;
    logic               front_on;
    logic               soft_rst;
  } pmac_core_t;

  typedef struct packed {
    logic [5:0][15:0] word;
  } pmac_thr_t;

endpackage : pmac_pkg

// File: pmac_thr_if.sv
// Threshold store link between control core and threshold memory
`timescale 1ns/100ps
`default_nettype none
interface pmac_thr_if;
  logic             wr;
  logic [2:0]       idx;
  logic [15:0]      wdata;
  logic             soft_rst;
  logic [5:0][15:0] words;

  modport ctrl  (output wr, idx, wdata, soft_rst, input words);
  modport store (input wr, idx, wdata, soft_rst, output words);
endinterface : pmac_thr_if
`default_nettype wire

// File: pmac_thr_mem.sv
// Six-word limit threshold memory with reset defaults
`timescale 1ns/100ps
`default_nettype none
`include "pmac_params.svh"
module pmac_thr_mem (
  input  wire logic  core_clk,
  input  wire logic  arst_n,
  pmac_thr_if.store  thr
);
  import pmac_pkg::*;

  localparam logic [5:0][15:0] THR_RST = {
    `PMAC_RST_POWER, `PMAC_RST_DIE_HEAT, `PMAC_RST_RAIL_LOW,
    `PMAC_RST_RAIL_HIGH, `PMAC_RST_SHUNT_HIGH, `PMAC_RST_SHUNT_LOW};

  pmac_thr_t s_r;
  pmac_thr_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (thr.soft_rst) begin
      s_nxt.word = THR_RST;
    end else if (thr.wr && (thr.idx < 3'h6)) begin
      s_nxt.word[thr.idx] = thr.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r.word <= THR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign thr.words = s_r.word;
endmodule : pmac_thr_mem
`default_nettype wire

// File: pmac_core.sv
// Conversion sequencing, limit checks and alert pin control
`timescale 1ns/100ps
`default_nettype none
`include "pmac_params.svh"
module pmac_core #(
  parameter int unsigned SETTLE_US = `PMAC_SETTLE_US
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             adc_start,
  output logic             filter_clear,
  output logic      [1:0]  adc_channel,
  output logic      [12:0] adc_ct_us,
  output logic             front_end_on,
  input  wire logic        adc_valid,
  input  wire logic [15:0] adc_data,
  input  wire logic        pwr_valid,
  input  wire logic [15:0] pwr_data,
  input  wire logic        math_ovf,
  input  wire logic        trim_ok,
  output logic             alert_o,
  output logic             alert_oe
);
  import pmac_pkg::*;

  localparam logic [4:0]  US_LAST     = 5'(`PMAC_US_CYC - 1);
  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_US - 1);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic pmac_core_t rst_val();
    pmac_core_t r;
    r          = '0;
    r.state    = PMAC_SETTLE;
    r.mode     = `PMAC_MODE_CONT;
    r.chen     = 3'h7;
    r.go       = 1'b1;
    r.ct       = {3{`PMAC_CT_RST_US}};
    return r;
  endfunction : rst_val

  localparam pmac_core_t CORE_RST = rst_val();

  function automatic logic [1:0] first_en(input logic [2:0] en, input logic [1:0] from);
    logic [1:0] r;
    r = `PMAC_NO_CH;
    for (int i = 2; i >= 0; i--) begin
      if (en[i] && (2'(i) >= from)) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : first_en

  function automatic logic [12:0] clamp_ct(input logic [15:0] v);
    logic [12:0] r;
    if (v < 16'(`PMAC_CT_MIN_US)) begin
      r = `PMAC_CT_MIN_US;
    end else if (v > 16'(`PMAC_CT_MAX_US)) begin
      r = `PMAC_CT_MAX_US;
    end else begin
      r = v[12:0];
    end
    return r;
  endfunction : clamp_ct

  // Limit check of one result; latched flags only ever set
  function automatic logic [5:0] apply_cmp(input logic [5:0] f, input logic latch,
                                           input logic [1:0] ch, input logic [15:0] v,
                                           input logic [5:0][15:0] w);
    logic [5:0] cond;
    logic [5:0] cov;
    cond = '0;
    cov  = '0;
    unique case (ch)
      2'h0: begin
        cov     = 6'h03;
        cond[0] = $signed(v) < $signed(w[0]);
        cond[1] = $signed(v) > $signed(w[1]);
      end
      2'h1: begin
        cov     = 6'h0c;
        cond[2] = v > w[2];
        cond[3] = v < w[3];
      end
      2'h2: begin
        cov     = 6'h10;
        cond[4] = v > w[4];
      end
      2'h3: begin
        cov     = 6'h20;
        cond[5] = $signed(v) > $signed(w[5]);
      end
    endcase
    return latch ? (f | cond) : ((f & ~cov) | cond);
  endfunction : apply_cmp

  // ----------------------------------------------------------------------
  // Threshold memory
  // ----------------------------------------------------------------------
  pmac_core_t s_r;
  pmac_core_t s_nxt;
  pmac_thr_if thr ();

  pmac_thr_mem u_thr_mem (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .thr      (thr.store)
  );

  assign thr.wr       = reg_wr && (reg_addr >= `PMAC_A_THR_FIRST) &&
                        (reg_addr <= `PMAC_A_THR_LAST);
  assign thr.idx      = 3'(reg_addr - `PMAC_A_THR_FIRST);
  assign thr.wdata    = reg_wdata;
  assign thr.soft_rst = s_r.soft_rst;

  // ----------------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------------
  always_comb begin
    logic               tick;
    logic               rd_diag;
    logic               restart;
    logic [1:0]         nch;
    logic [10:0]        avg_last;
    logic signed [26:0] avg_val;
    logic               cond;
    tick     = 1'b0;
    rd_diag  = reg_rd && (reg_addr == `PMAC_A_DIAG);
    restart  = 1'b0;
    nch      = `PMAC_NO_CH;
    avg_last = 11'((32'h1 << s_r.avg_log2) - 32'h1);
    avg_val  = '0;
    cond     = 1'b0;
    s_nxt              = s_r;
    s_nxt.adc_start    = 1'b0;
    s_nxt.filter_clear = 1'b0;
    s_nxt.soft_rst     = 1'b0;

    // Microsecond time base
    if (s_r.us_div == US_LAST) begin
      s_nxt.us_div = '0;
      tick         = 1'b1;
    end else begin
      s_nxt.us_div = s_r.us_div + 5'h1;
    end

    // Clears come first so that a same-cycle event wins
    // Ready clears on read
    if (rd_diag) begin
      s_nxt.done_flag  = 1'b0;
      s_nxt.ovf_flag   = 1'b0;
      s_nxt.alert_hold = 1'b0;
      if (s_r.hold_en) begin
        s_nxt.flags = '0;
      end
    end
    if (reg_wr && (reg_addr == `PMAC_A_ADC_CFG) &&
        (reg_wdata[1:0] != `PMAC_MODE_SHUT)) begin
      s_nxt.done_flag = 1'b0;
    end

    // ----------------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------------
    if (reg_wr) begin
      unique case (reg_addr)
        `PMAC_A_CFG:      s_nxt.soft_rst = reg_wdata[`PMAC_CFG_RST_BIT];
        `PMAC_A_ADC_CFG: begin
          s_nxt.mode = reg_wdata[1:0];
          s_nxt.chen = reg_wdata[4:2];
          restart    = 1'b1;
        end
        `PMAC_A_CT_SHUNT: s_nxt.ct[0] = clamp_ct(reg_wdata);
        `PMAC_A_CT_RAIL:  s_nxt.ct[1] = clamp_ct(reg_wdata);
        `PMAC_A_CT_HEAT:  s_nxt.ct[2] = clamp_ct(reg_wdata);
        `PMAC_A_AVG: begin
          s_nxt.avg_log2 = (reg_wdata[3:0] > `PMAC_AVG_MAX_LOG2) ?
                           `PMAC_AVG_MAX_LOG2 : reg_wdata[3:0];
        end
        `PMAC_A_DIAG: begin
          s_nxt.hold_en = reg_wdata[`PMAC_DG_HOLD];
          s_nxt.conversion_done_alert_enable_en = reg_wdata[`PMAC_DG_CONVERSION_DONE_ALERT_ENABLE];
          s_nxt.slow_en = reg_wdata[`PMAC_DG_SLOW];
          s_nxt.invert  = reg_wdata[`PMAC_DG_INV];
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------------
    if (reg_rd) begin
      s_nxt.rdata = '0;
      unique case (reg_addr)
        `PMAC_A_ADC_CFG:  s_nxt.rdata = {11'h0, s_r.chen, s_r.mode};
        `PMAC_A_CT_SHUNT: s_nxt.rdata = {3'h0, s_r.ct[0]};
        `PMAC_A_CT_RAIL:  s_nxt.rdata = {3'h0, s_r.ct[1]};
        `PMAC_A_CT_HEAT:  s_nxt.rdata = {3'h0, s_r.ct[2]};
        `PMAC_A_AVG:      s_nxt.rdata = {12'h0, s_r.avg_log2};
        `PMAC_A_DIAG: begin
          s_nxt.rdata[`PMAC_DG_HOLD] = s_r.hold_en;
          s_nxt.rdata[`PMAC_DG_CONVERSION_DONE_ALERT_ENABLE] = s_r.conversion_done_alert_enable_en;
          s_nxt.rdata[`PMAC_DG_SLOW] = s_r.slow_en;
          s_nxt.rdata[`PMAC_DG_INV]  = s_r.invert;
          s_nxt.rdata[`PMAC_DG_OVF]  = s_r.ovf_flag;
          s_nxt.rdata[`PMAC_DG_MEM]  = trim_ok;
          s_nxt.rdata[`PMAC_DG_DONE] = s_r.done_flag;
          s_nxt.rdata[5:0]           = s_r.flags;
        end
        default: begin
          if ((reg_addr >= `PMAC_A_THR_FIRST) && (reg_addr <= `PMAC_A_THR_LAST)) begin
            s_nxt.rdata = thr.words[3'(reg_addr - `PMAC_A_THR_FIRST)];
          end else if ((reg_addr >= `PMAC_A_RES_FIRST) &&
                       (reg_addr <= `PMAC_A_RES_LAST)) begin
            s_nxt.rdata = s_r.res[2'(reg_addr - `PMAC_A_RES_FIRST)];
          end
        end
      endcase
    end

    // ----------------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------------
    unique case (s_r.state)
      PMAC_SETTLE: begin
        if (tick) begin
          s_nxt.settle_cnt = s_r.settle_cnt + 16'h1;
          if (s_r.settle_cnt == SETTLE_LAST) begin
            s_nxt.state = PMAC_IDLE;
          end
        end
      end
      PMAC_IDLE: begin
        s_nxt.front_on = 1'b0;
        if (s_r.go && (s_r.mode != `PMAC_MODE_SHUT)) begin
          nch = first_en(s_r.chen, 2'h0);
          if (nch == `PMAC_NO_CH) begin
            s_nxt.go = 1'b0;
          end
        end
      end
      PMAC_CONV: begin
        if (tick) begin
          s_nxt.us_cnt = s_r.us_cnt + 13'h1;
          if (s_r.us_cnt == (s_r.ct[s_r.ch] - 13'h1)) begin
            s_nxt.state = PMAC_WAIT;
          end
        end
      end
      PMAC_WAIT: begin
        if (adc_valid) begin
          s_nxt.acc[s_r.ch] = 27'($signed(s_r.acc[s_r.ch]) + $signed(adc_data));
          if (!s_r.slow_en) begin
            s_nxt.flags = apply_cmp(s_nxt.flags, s_r.hold_en, s_r.ch, adc_data, thr.words);
          end
          nch = first_en(s_r.chen, s_r.ch + 2'h1);
          if (nch == `PMAC_NO_CH) begin
            if (s_r.avg_cnt == avg_last) begin
              for (int i = 0; i < 3; i++) begin
                if (s_r.chen[i]) begin
                  avg_val = $signed(s_nxt.acc[i]) >>> s_r.avg_log2;
                  s_nxt.res[i] = avg_val[15:0];
                  if (s_r.slow_en) begin
                    s_nxt.flags = apply_cmp(s_nxt.flags, s_r.hold_en, 2'(i),
                                            avg_val[15:0], thr.words);
                  end
                end
              end
              s_nxt.acc       = '0;
              s_nxt.avg_cnt   = '0;
              s_nxt.done_flag = 1'b1;
              if (s_r.mode == `PMAC_MODE_CONT) begin
                nch = first_en(s_r.chen, 2'h0);
              end else begin
                s_nxt.go    = 1'b0;
                s_nxt.state = PMAC_IDLE;
              end
            end else begin
              s_nxt.avg_cnt = s_r.avg_cnt + 11'h1;
              nch           = first_en(s_r.chen, 2'h0);
            end
          end
        end
      end
    endcase

    if (nch != `PMAC_NO_CH) begin
      s_nxt.state        = PMAC_CONV;
      s_nxt.ch           = nch;
      s_nxt.us_cnt       = '0;
      s_nxt.adc_start    = 1'b1;
      s_nxt.filter_clear = 1'b1;
      s_nxt.ch_out       = nch;
      s_nxt.ct_out       = s_r.ct[nch];
      s_nxt.front_on     = 1'b1;
    end

    if (pwr_valid) begin
      s_nxt.res[3] = pwr_data;
      s_nxt.flags  = apply_cmp(s_nxt.flags, s_r.hold_en, 2'h3, pwr_data, thr.words);
    end

    s_nxt.ovf_flag = s_nxt.ovf_flag | math_ovf;

    if (restart) begin
      s_nxt.acc     = '0;
      s_nxt.avg_cnt = '0;
      s_nxt.go      = (reg_wdata[1:0] != `PMAC_MODE_SHUT);
      if (s_r.state != PMAC_SETTLE) begin
        s_nxt.state    = PMAC_IDLE;
        s_nxt.front_on = 1'b0;
        s_nxt.adc_start    = 1'b0;
        s_nxt.filter_clear = 1'b0;
      end
    end

    // ----------------------------------------------------------------------
    // Alert pin
    // ----------------------------------------------------------------------
    // Shared indicator
    cond = (|s_nxt.flags) | (s_nxt.conversion_done_alert_enable_en & s_nxt.done_flag);
    s_nxt.alert_hold = s_nxt.alert_hold | (s_nxt.hold_en & cond);
    s_nxt.alert_oe   = (s_nxt.hold_en ? s_nxt.alert_hold : cond) ^ s_nxt.invert;
    s_nxt.alert_o    = 1'b0;

    if (s_r.soft_rst) begin
      s_nxt = CORE_RST;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata    = s_r.rdata;
  assign adc_start    = s_r.adc_start;
  assign filter_clear = s_r.filter_clear;
  assign adc_channel  = s_r.ch_out;
  assign adc_ct_us    = s_r.ct_out;
  assign front_end_on = s_r.front_on;
  assign alert_o      = s_r.alert_o;
  assign alert_oe     = s_r.alert_oe;
endmodule : pmac_core
`default_nettype wire

// File: pmac_core_monitor.sv
// Port checker of the alert control core
`timescale 1ns/100ps
`default_nettype none
`include "pmac_params.svh"
module pmac_core_monitor #(
  parameter int unsigned SETTLE_US = 3
) (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        adc_start,
  input wire logic        filter_clear,
  input wire logic [1:0]  adc_channel,
  input wire logic [12:0] adc_ct_us,
  input wire logic        front_end_on,
  input wire logic        alert_o
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  alert_level_low_a: assert property (alert_o == 1'b0)
    else $error("alert data level not low");
  filter_with_start_a: assert property (adc_start == filter_clear)
    else $error("filter restart apart from start");
  start_powered_a: assert property (adc_start |-> front_end_on)
    else $error("start with front end off");
  conv_time_range_a: assert property (adc_start |-> adc_ct_us inside {[50:4120]})
    else $error("conversion time out of range");
  channel_legal_a: assert property (adc_start |-> adc_channel != `PMAC_NO_CH)
    else $error("start on no channel");
  conv_min_gap_a: assert property (adc_start |=> (!adc_start ||
    $past(reg_wr && reg_addr == `PMAC_A_ADC_CFG, 2)) [*8])
    else $error("conversion restarted too soon");
  link_hold_a: assert property (!adc_start && !$past(reg_wr) && !$past(reg_wr, 2)
    |-> $stable(adc_channel) && $stable(adc_ct_us))
    else $error("channel or time moved without start");
  unmapped_zero_a: assert property (reg_rd && reg_addr > `PMAC_A_RES_LAST
    |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  soft_reset_stop_a: assert property (reg_wr && reg_addr == `PMAC_A_CFG && reg_wdata[15]
    |-> ##[1:2] !front_end_on)
    else $error("front end on after reset bit");
  rdata_hold_a: assert property (!$past(reg_rd) && !$past(reg_wr) && !$past(reg_wr, 2)
    |-> $stable(reg_rdata))
    else $error("read data moved without read");

  cover property (adc_start);
  cover property (reg_rd && reg_addr == `PMAC_A_DIAG);
  cover property ($fell(front_end_on));
endmodule : pmac_core_monitor

bind pmac_core pmac_core_monitor #(.SETTLE_US(SETTLE_US)) u_mon (
  .core_clk(core_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .adc_start(adc_start), .filter_clear(filter_clear), .adc_channel(adc_channel),
  .adc_ct_us(adc_ct_us), .front_end_on(front_end_on), .alert_o(alert_o));
`default_nettype wire

// File: pmac_front_model.sv
// Behavioural converter front end answering each started conversion
`timescale 1ns/100ps
`default_nettype none
module pmac_front_model (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             adc_start,
  input  wire logic [1:0]       adc_channel,
  input  wire logic [12:0]      adc_ct_us,
  input  wire logic [2:0][15:0] vals,
  output logic                  adc_valid,
  output logic      [15:0]      adc_data
);
  int         cnt;
  logic [1:0] ch;
  always @(negedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt       <= 0;
      ch        <= 2'h0;
      adc_valid <= 1'b0;
      adc_data  <= 16'h5a5a;
    end else begin
      adc_valid <= 1'b0;
      adc_data  <= ~adc_data;
      if (adc_start) begin
        ch  <= adc_channel;
        cnt <= int'(adc_ct_us) * 25 + 50;
      end else if (cnt == 1) begin
        cnt       <= 0;
        adc_valid <= 1'b1;
        adc_data  <= vals[ch];
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : pmac_front_model
`default_nettype wire

// File: pmac_core_tb.sv
// Self-checking bench of the alert control core
`timescale 1ns/100ps
`default_nettype none
`include "pmac_params.svh"
module pmac_core_tb;
  logic             core_clk, arst_n, reg_wr, reg_rd, pwr_valid, math_ovf, trim_ok;
  logic [7:0]       reg_addr;
  logic [15:0]      reg_wdata, reg_rdata, pwr_data, adc_data;
  logic             adc_start, filter_clear, front_end_on, adc_valid, alert_o, alert_oe;
  logic [1:0]       adc_channel;
  logic [12:0]      adc_ct_us;
  logic [2:0][15:0] vals;
  int               err_count, tests_run;
  logic [15:0]      thr_rst [6] = '{`PMAC_RST_SHUNT_LOW, `PMAC_RST_SHUNT_HIGH,
    `PMAC_RST_RAIL_HIGH, `PMAC_RST_RAIL_LOW, `PMAC_RST_DIE_HEAT, `PMAC_RST_POWER};

  pmac_core #(.SETTLE_US(3)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .adc_start(adc_start), .filter_clear(filter_clear),
    .adc_channel(adc_channel), .adc_ct_us(adc_ct_us), .front_end_on(front_end_on),
    .adc_valid(adc_valid), .adc_data(adc_data), .pwr_valid(pwr_valid),
    .pwr_data(pwr_data), .math_ovf(math_ovf), .trim_ok(trim_ok),
    .alert_o(alert_o), .alert_oe(alert_oe));
  pmac_front_model u_front (.core_clk(core_clk), .arst_n(arst_n),
    .adc_start(adc_start), .adc_channel(adc_channel), .adc_ct_us(adc_ct_us),
    .vals(vals), .adc_valid(adc_valid), .adc_data(adc_data));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge core_clk);
    reg_rd = 1'b1; reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask : rd
  task automatic trig();
    int n;
    n = 0;
    wr(`PMAC_A_ADC_CFG, 16'h001d);
    while (front_end_on !== 1'b1 && n < 10) begin @(negedge core_clk); n++; end
    while (front_end_on !== 1'b0 && n < 20000) begin @(negedge core_clk); n++; end
    chk({15'h0, n < 20000}, 16'h0001);
    repeat (2) @(negedge core_clk);
  endtask : trig
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (80000) @(posedge core_clk);
    err_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, pwr_valid, pwr_data, math_ovf} = '0;
    arst_n = 1'b0; trim_ok = 1'b1; vals = {16'h0040, 16'h0100, 16'h0010};
    err_count = 0; tests_run = 0;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    wr(`PMAC_A_ADC_CFG, 16'h001c);
    for (int i = 0; i < 6; i++) rd(`PMAC_A_THR_FIRST + 8'(i), thr_rst[i]);
    rd(`PMAC_A_DIAG, 16'h0100);
    rd(8'h40, 16'h0000);
    $display("test reset values done");
    wr(`PMAC_A_CT_SHUNT, 16'h000a);
    rd(`PMAC_A_CT_SHUNT, 16'h0032);
    wr(`PMAC_A_CT_RAIL, 16'h1068);
    rd(`PMAC_A_CT_RAIL, 16'h1018);
    wr(`PMAC_A_CT_RAIL, 16'h0032);
    wr(`PMAC_A_CT_HEAT, 16'h0032);
    wr(`PMAC_A_AVG, 16'h000f);
    rd(`PMAC_A_AVG, 16'h000a);
    wr(`PMAC_A_AVG, 16'h0000);
    repeat (100) @(negedge core_clk);
    chk({15'h0, front_end_on}, 16'h0000);
    $display("test config done");
    wr(`PMAC_A_THR_FIRST + 8'h01, 16'h0008);
    trig();
    chk({15'h0, alert_oe}, 16'h0001);
    wr(`PMAC_A_ADC_CFG, 16'h001c);
    rd(`PMAC_A_DIAG, 16'h0182);
    rd(`PMAC_A_DIAG, 16'h0102);
    for (int i = 0; i < 3; i++) rd(`PMAC_A_RES_FIRST + 8'(i), vals[i]);
    $display("test limit done");
    wr(`PMAC_A_DIAG, 16'h8000);
    trig();
    vals[0] = 16'h0004;
    trig();
    chk({15'h0, alert_oe}, 16'h0001);
    rd(`PMAC_A_DIAG, 16'h8182);
    repeat (2) @(negedge core_clk);
    chk({15'h0, alert_oe}, 16'h0000);
    rd(`PMAC_A_RES_FIRST, 16'h0004);
    $display("test hold done");
    wr(`PMAC_A_DIAG, 16'h4000);
    trig();
    chk({15'h0, alert_oe}, 16'h0001);
    rd(`PMAC_A_DIAG, 16'h4180);
    wr(`PMAC_A_DIAG, 16'h1000);
    repeat (2) @(negedge core_clk);
    chk({15'h0, alert_oe}, 16'h0001);
    rd(`PMAC_A_DIAG, 16'h1100);
    wr(`PMAC_A_DIAG, 16'h0000);
    $display("test ready and polarity done");
    wr(`PMAC_A_AVG, 16'h0001);
    wr(`PMAC_A_DIAG, 16'ha000);
    wr(`PMAC_A_THR_FIRST + 8'h01, 16'h0002);
    trig();
    rd(`PMAC_A_DIAG, 16'ha182);
    rd(`PMAC_A_RES_FIRST, 16'h0004);
    rd(`PMAC_A_RES_FIRST + 8'h01, vals[1]);
    wr(`PMAC_A_DIAG, 16'h0000);
    wr(`PMAC_A_AVG, 16'h0000);
    $display("test averaged compare done");
    @(negedge core_clk); math_ovf = 1'b1;
    @(negedge core_clk); math_ovf = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({15'h0, alert_oe}, 16'h0000);
    rd(`PMAC_A_DIAG, 16'h0300);
    wr(`PMAC_A_THR_LAST, 16'h0100);
    pwr_data = 16'h0200;
    @(negedge core_clk); pwr_valid = 1'b1;
    @(negedge core_clk); pwr_valid = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({15'h0, alert_oe}, 16'h0001);
    rd(`PMAC_A_DIAG, 16'h0120);
    $display("test overflow and power done");
    wr(`PMAC_A_ADC_CFG, 16'h001e);
    repeat (20) @(negedge core_clk);
    chk({15'h0, front_end_on}, 16'h0001);
    wr(`PMAC_A_CFG, 16'h8000);
    repeat (2) @(negedge core_clk);
    chk({15'h0, front_end_on}, 16'h0000);
    rd(`PMAC_A_THR_LAST, 16'h7fff);
    rd(`PMAC_A_THR_FIRST + 8'h01, 16'h7fff);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule : pmac_core_tb
`default_nettype wire
